// ==== dv/tapdet_host.sv ====
// Host model that reads the tap source register
`timescale 1ns/10ps
module tapdet_host (
    input wire logic mclk, // Clock
    output logic rd_en, // Read strobe
    output logic [6:0] rd_addr, // Read address
    input wire logic [7:0] rd_data // Read data
);
    initial rd_en = 1'b0;
    initial rd_addr = 7'h00;
    // One-cycle strobe; data is picked up a cycle later, address then scrambled
    task automatic read(input logic [6:0] addr, output logic [7:0] data);
        @(negedge mclk);
        rd_en = 1'b1;
        rd_addr = addr;
        @(negedge mclk);
        rd_en = 1'b0;
        rd_addr = ~addr;
        data = rd_data;
    endtask
endmodule // tapdet_host

// ==== dv/tapdet_props.sv ====
// Port checker for the tap detector
`timescale 1ns/10ps
module tapdet_props (
    input wire logic mclk, // Clock
    input wire logic rst, // Reset
    input wire logic sample_valid, // Sample strobe
    input wire tapdet_pkg::tapdet_cfg_type cfg, // Config
    input wire logic rd_en, // Read strobe
    input wire logic [6:0] rd_addr, // Read address
    input wire logic [7:0] rd_data, // Read data
    input wire logic int1, // Pin one
    input wire logic int2 // Pin two
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    logic seen_sel;
    logic lat1;
    logic rt2;
    logic idle;
    assign lat1 = cfg.latch_interrupt_enable & ~cfg.single_double_sel & cfg.pin1_single_route;
    assign rt2 = cfg.pin2_single_route | cfg.pin2_double_route;
    assign idle = cfg.inactive_state;
    // Remembers whether double taps were ever allowed since reset
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            seen_sel <= 1'b0;
        else if (cfg.single_double_sel)
            seen_sel <= 1'b1;
    end
    chk_top_zero: assert property (rd_data[7] == 1'b0)
        else $error("source bit 7 set");
    chk_unmapped_zero: assert property ($past(rd_en) &&
        $past(rd_addr) != 7'h1C |-> rd_data == 8'h00) else $error("unmapped read not zero");
    chk_axis_enabled: assert property (rd_data[6] |-> rd_data[2:0] != 3'h0 &&
        (rd_data[2:0] & ~cfg.tap_axis_en) == 3'h0) else $error("bad axis bits");
    chk_no_double: assert property (!seen_sel |-> !rd_data[4])
        else $error("double tap without select");
    chk_inactive_low: assert property (idle && $past(idle) |-> !int1 && !int2)
        else $error("tap interrupt while inactive");
    chk_pin2_route: assert property (!rt2 && !$past(rt2) |-> !int2)
        else $error("unrouted second pin high");
    chk_latch_hold: assert property (lat1 && int1 && !rd_en && !$past(rd_en) && !idle |=> int1)
        else $error("latched interrupt dropped");
    chk_latch_release: assert property (lat1 && rd_en && rd_addr == 7'h1C &&
        !sample_valid ##1 !sample_valid |=> !int1) else $error("latch not released");
    chk_int_sample: assert property ($changed(int1) && !cfg.latch_interrupt_enable &&
        !idle && !$past(idle) |-> $past(sample_valid, 2)) else $error("pulse edge off sample");
    cover property ($rose(int1) && !lat1);
    cover property (rd_data[4]);
    cover property (lat1 && $fell(int1));
endmodule // tapdet_props

bind tapdet tapdet_props tapdet_props_inst (.mclk(mclk), .rst(rst), .sample_valid(sample_valid),
    .cfg(cfg), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .int1(int1), .int2(int2));

// ==== dv/testbench.sv ====
// Self-checking bench for the tap detector
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    tapdet_pkg::tapdet_sample_type sample = '0;
    tapdet_pkg::tapdet_cfg_type cfg = '0;
    logic rd_en;
    logic [6:0] rd_addr;
    logic [7:0] rd_data;
    logic int1;
    logic int2;
    logic [15:0] lvl = 16'h0000;
    int ax = 2;
    int n_errors = 0;
    int total_checks = 0;

    always #25 mclk = ~mclk;

    tapdet tapdet_inst (.mclk(mclk), .rst(rst), .sample_valid(sample_valid), .sample(sample),
        .cfg(cfg), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data), .int1(int1), .int2(int2));
    tapdet_host tapdet_host_inst (.mclk(mclk), .rd_en(rd_en), .rd_addr(rd_addr), .rd_data(rd_data));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        if (n_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    function automatic tapdet_pkg::tapdet_cfg_type base();
        tapdet_pkg::tapdet_cfg_type c;
        c = '0;
        c.tap_axis_en = 3'h7;
        c.tap_threshold_field = 5'h01;
        c.shock_field = 2'h1;
        return c;
    endfunction

    // One sample every three cycles, so a registered pin has settled on return
    task automatic smp();
        @(negedge mclk);
        sample.axis[ax] = lvl;
        sample_valid = 1'b1;
        @(negedge mclk);
        sample_valid = 1'b0;
        @(negedge mclk);
    endtask

    task automatic flat(input int n);
        repeat (n) smp();
    endtask

    // Steps of 4096 give a slope of 2048, over the threshold for field values below 2
    task automatic tap(input logic neg, input int over);
        repeat (over)
        begin
            lvl = neg ? lvl - 16'h1000 : lvl + 16'h1000;
            smp();
        end
        smp();
    endtask

    task automatic restart(input tapdet_pkg::tapdet_cfg_type c);
        @(negedge mclk);
        rst = 1'b1;
        cfg = c;
        lvl = 16'h0000;
        sample = '0;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        smp();
    endtask

    task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        tapdet_host_inst.read(addr, d);
        check(d, exp);
    endtask

    task automatic s_reset();
        restart(base());
        check({6'h00, int1, int2}, 8'h00);
        rd(7'h1C, 8'h00);
        rd(7'h05, 8'h00);
    endtask

    task automatic s_pulse();
        tapdet_pkg::tapdet_cfg_type c;
        int n;
        for (int q = 0; q < 3; q++)
        begin
            c = base();
            c.quiet_field = q[1:0];
            c.pin1_single_route = 1'b1;
            restart(c);
            tap(1'b0, 1);
            n = 0;
            repeat (12)
            begin
                n += (int1 === 1'b1);
                check({7'h00, int2}, 8'h00);
                smp();
            end
            check(n[7:0], (q == 0) ? 8'h02 : 8'(q * 4));
            rd(7'h1C, 8'h64);
        end
    endtask

    task automatic s_axes();
        tapdet_pkg::tapdet_cfg_type c;
        c = base();
        c.pin2_single_route = 1'b1;
        for (int a = 0; a < 3; a++)
        begin
            ax = a;
            restart(c);
            tap(a[0], 1);
            check({6'h00, int1, int2}, 8'h01);
            rd(7'h1C, 8'h60 | {4'h0, a[0], 3'h0} | (8'h01 << a));
        end
        ax = 2;
    endtask

    // Rows: axis enables, threshold, shock code, samples over, expected source
    task automatic s_table();
        tapdet_pkg::tapdet_cfg_type c;
        logic [23:0] rows [8] = '{24'h711164, 24'h721100, 24'h311100, 24'h710364, 24'h710600,
            24'h711664, 24'h710464, 24'h710500};
        for (int i = 0; i < 8; i++)
        begin
            c = base();
            c.tap_axis_en = rows[i][22:20];
            c.tap_threshold_field = {1'b0, rows[i][19:16]};
            c.shock_field = rows[i][13:12];
            restart(c);
            tap(1'b0, rows[i][11:8]);
            rd(7'h1C, rows[i][7:0]);
        end
    endtask

    task automatic s_latch();
        tapdet_pkg::tapdet_cfg_type c;
        c = base();
        c.latch_interrupt_enable = 1'b1;
        c.pin1_single_route = 1'b1;
        restart(c);
        tap(1'b0, 1);
        flat(10);
        check({7'h00, int1}, 8'h01);
        rd(7'h1C, 8'h64);
        @(negedge mclk);
        check({7'h00, int1}, 8'h00);
        rd(7'h1C, 8'h00);
        c.single_double_sel = 1'b1;
        restart(c);
        tap(1'b0, 1);
        flat(10);
        check({7'h00, int1}, 8'h00);
    endtask

    task automatic s_inactive();
        tapdet_pkg::tapdet_cfg_type c;
        c = base();
        c.inactive_state = 1'b1;
        c.pin1_single_route = 1'b1;
        restart(c);
        tap(1'b0, 1);
        check({7'h00, int1}, 8'h00);
        rd(7'h1C, 8'h00);
    endtask

    // Rows: select, samples between taps, expected source
    task automatic s_double();
        tapdet_pkg::tapdet_cfg_type c;
        logic [19:0] rows [6] = '{20'h10454, 20'h00464, 20'h11864, 20'h10064, 20'h11154,
            20'h11264};
        c = base();
        c.pin1_double_route = 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            c.single_double_sel = rows[i][16];
            restart(c);
            tap(1'b0, 1);
            flat(rows[i][15:8]);
            tap(1'b0, 1);
            check({7'h00, int1}, {7'h00, rows[i][7:0] == 8'h54});
            rd(7'h1C, rows[i][7:0]);
        end
    endtask

    initial
    begin
        s_reset();
        s_pulse();
        s_axes();
        s_table();
        s_latch();
        s_inactive();
        s_double();
        summarize();
    end
endmodule // testbench

// ==== hw/tapdet.sv ====
// Single and double tap detector with source register and two interrupt pins
`timescale 1ns/10ps
`include "tapdet_defines.svh"

module tapdet (
    input wire logic mclk, // 20 MHz clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic sample_valid, // One-cycle strobe per output sample
    input wire tapdet_pkg::tapdet_sample_type sample, // Signed samples, full scale = 2^15
    input wire tapdet_pkg::tapdet_cfg_type cfg, // Configuration bits
    input wire logic rd_en, // Register read strobe
    input wire logic [6:0] rd_addr, // Register read address
    output logic [7:0] rd_data, // Read data, valid cycle after rd_en
    output logic int1, // First interrupt pin
    output logic int2 // Second interrupt pin
);

    tapdet_pkg::tapdet_state_type state;
    logic [2:0][15:0] prev;
    logic prev_ok;
    logic [2:0] over;
    logic [2:0] neg;
    logic any_over;
    logic [16:0] thr;
    logic [8:0] cnt;
    logic [8:0] cnt_p1;
    logic [8:0] shock_len;
    logic [8:0] quiet_len;
    logic [8:0] dur_len;
    logic [2:0] tap_axes;
    logic tap_sign;
    logic [7:0] src;
    logic rd_hit;
    logic [1:0] evt;
    logic [1:0] routed;
    logic [1:0] latch_ok;
    logic [1:0] kind_int;

    assign thr = 17'(cfg.tap_threshold_field) << `TAPDET_THS_SHIFT; // R2

    assign shock_len = (cfg.shock_field == 2'h0) ? `TAPDET_SHOCK_BASE :
        9'(cfg.shock_field) * `TAPDET_SHOCK_STEP; // R5
    assign quiet_len = (cfg.quiet_field == 2'h0) ? `TAPDET_QUIET_BASE :
        9'(cfg.quiet_field) * `TAPDET_QUIET_STEP; // R8
    assign dur_len = (cfg.duration_window_field == 4'h0) ? `TAPDET_DUR_BASE :
        9'(cfg.duration_window_field) * `TAPDET_DUR_STEP; // R10

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_axis
            logic signed [16:0] diff;
            logic signed [16:0] slope;
            logic [16:0] mag;
            assign diff = signed'({sample.axis[g][15], sample.axis[g]})
                - signed'({prev[g][15], prev[g]});
            assign slope = diff >>> 1; // R20
            assign mag = slope[16] ? 17'(-slope) : slope; // R3
            assign neg[g] = slope[16];
            assign over[g] = prev_ok && cfg.tap_axis_en[g] && (mag > thr); // R1

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    prev[g] <= 16'h0000;
                end
                else if (sample_valid)
                begin
                    prev[g] <= sample.axis[g];
                end
            end
        end
    endgenerate

    assign any_over = |over;

    // No slope exists until one sample has been stored
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            prev_ok <= 1'b0;
        end
        else if (sample_valid)
        begin
            prev_ok <= 1'b1;
        end
    end

    assign cnt_p1 = cnt + 9'h001;

    // Window sequencer, advanced once per output sample
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state <= tapdet_pkg::ST_IDLE;
            cnt <= 9'h000;
        end
        else if (sample_valid) // R22
        begin
            case (state)
                tapdet_pkg::ST_IDLE:
                begin
                    cnt <= 9'h000;
                    if (any_over)
                    begin
                        state <= tapdet_pkg::ST_SHOCK1;
                    end
                end
                tapdet_pkg::ST_SHOCK1:
                begin
                    if (!any_over)
                    begin
                        state <= tapdet_pkg::ST_QUIET;
                        cnt <= 9'h000;
                    end
                    else if (cnt_p1 >= shock_len)
                    begin
                        state <= tapdet_pkg::ST_SETTLE; // R4
                    end
                    else
                    begin
                        cnt <= cnt_p1;
                    end
                end
                tapdet_pkg::ST_QUIET:
                begin
                    if (cfg.single_double_sel && any_over)
                    begin
                        state <= tapdet_pkg::ST_SETTLE; // R6
                    end
                    else if (cnt_p1 >= quiet_len)
                    begin
                        cnt <= 9'h000;
                        state <= cfg.single_double_sel ? tapdet_pkg::ST_DUR :
                            tapdet_pkg::ST_IDLE; // R9 R16
                    end
                    else
                    begin
                        cnt <= cnt_p1;
                    end
                end
                tapdet_pkg::ST_DUR:
                begin
                    if (any_over)
                    begin
                        state <= tapdet_pkg::ST_SHOCK2; // R21
                        cnt <= 9'h000;
                    end
                    else if (cnt_p1 >= dur_len)
                    begin
                        state <= tapdet_pkg::ST_IDLE; // R21
                    end
                    else
                    begin
                        cnt <= cnt_p1;
                    end
                end
                tapdet_pkg::ST_SHOCK2:
                begin
                    if (!any_over)
                    begin
                        state <= tapdet_pkg::ST_QUIET2;
                        cnt <= 9'h000;
                    end
                    else if (cnt_p1 >= shock_len)
                    begin
                        state <= tapdet_pkg::ST_SETTLE; // R4
                    end
                    else
                    begin
                        cnt <= cnt_p1;
                    end
                end
                tapdet_pkg::ST_QUIET2:
                begin
                    if (cnt_p1 >= quiet_len)
                    begin
                        state <= tapdet_pkg::ST_IDLE;
                    end
                    else
                    begin
                        cnt <= cnt_p1;
                    end
                end
                default:
                begin
                    if (!any_over)
                    begin
                        state <= tapdet_pkg::ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Axis and sign are taken on the crossing sample
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tap_axes <= 3'h0;
            tap_sign <= 1'b0;
        end
        else if (sample_valid && any_over &&
            (state == tapdet_pkg::ST_IDLE || state == tapdet_pkg::ST_DUR))
        begin
            tap_axes <= over; // R15
            tap_sign <= |(over & neg); // R14
        end
    end

    // Events are not generated at all during inactivity
    assign evt[0] = sample_valid && !any_over && !cfg.inactive_state &&
        (state == tapdet_pkg::ST_SHOCK1); // R4 R12
    assign evt[1] = sample_valid && !any_over && !cfg.inactive_state &&
        cfg.single_double_sel && (state == tapdet_pkg::ST_SHOCK2); // R16

    assign rd_hit = rd_en && (rd_addr == `TAPDET_SRC_ADDR);

    // Source flags: a new event wins over a clearing read
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            src <= `TAPDET_SRC_RESET;
        end
        else if (|evt)
        begin
            src <= `TAPDET_SRC_RESET;
            src[`TAPDET_SRC_ANY] <= 1'b1; // R13
            src[`TAPDET_SRC_SINGLE] <= evt[0]; // R13
            src[`TAPDET_SRC_DOUBLE] <= evt[1]; // R13
            src[`TAPDET_SRC_SIGN] <= tap_sign; // R14
            src[2:0] <= tap_axes; // R15
        end
        else if (rd_hit)
        begin
            src <= `TAPDET_SRC_RESET;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            rd_data <= 8'h00;
        end
        else if (rd_en)
        begin
            rd_data <= (rd_addr == `TAPDET_SRC_ADDR) ? src : 8'h00; // R13
        end
    end

    assign routed[0] = cfg.pin1_single_route | cfg.pin2_single_route;
    assign routed[1] = cfg.pin1_double_route | cfg.pin2_double_route;
    assign latch_ok[0] = cfg.latch_interrupt_enable && !cfg.single_double_sel &&
        routed[0]; // R17 R19
    assign latch_ok[1] = cfg.latch_interrupt_enable && cfg.single_double_sel &&
        routed[1]; // R17 R19

    // Index 0 is the single-tap interrupt, index 1 the double-tap one
    generate
        for (g = 0; g < 2; g++)
        begin : g_kind
            logic [8:0] pcnt;
            logic latched;

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    pcnt <= 9'h000;
                end
                else if (evt[g] && !latch_ok[g])
                begin
                    pcnt <= quiet_len; // R7
                end
                else if (sample_valid && pcnt != 9'h000)
                begin
                    pcnt <= pcnt - 9'h001;
                end
            end

            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    latched <= 1'b0;
                end
                else if (evt[g] && latch_ok[g])
                begin
                    latched <= 1'b1; // R17
                end
                else if (rd_hit)
                begin
                    latched <= 1'b0; // R18
                end
            end

            assign kind_int[g] = !cfg.inactive_state &&
                (latched || pcnt != 9'h000); // R12
        end
    endgenerate

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            int1 <= 1'b0;
            int2 <= 1'b0;
        end
        else
        begin
            int1 <= (cfg.pin1_single_route && kind_int[0]) ||
                (cfg.pin1_double_route && kind_int[1]); // R11
            int2 <= (cfg.pin2_single_route && kind_int[0]) ||
                (cfg.pin2_double_route && kind_int[1]); // R11
        end
    end

endmodule // tapdet

// ==== hw/tapdet_defines.svh ====
// Constants for the tap event detector: offsets, fields, window lengths
// Operation
// (R1) Host enables taps per axis
// (R2) Threshold is 5-bit, full scale over 32
// (R3) Slope magnitude of either sign compared
// (R4) Slope must drop before shock window ends
// (R5) Shock: code 0 is 4, else code times 8
// (R6) No crossing during quiet after first tap
// (R7) Unlatched interrupt pulse lasts quiet window
// (R8) Quiet: code 0 is 2, else code times 4
// (R9) Duration window starts after first quiet ends
// (R10) Duration: code 0 is 16, else times 32
// (R11) Per-pin route bits gate tap interrupts
// (R12) No tap interrupts during inactivity
// (R13) Source bit7 zero, bits 6-4 event flags
// (R14) Source bit3 gives tap sign
// (R15) Source bits 2-0 give X, Y, Z axis
// (R16) Select bit 0 means single taps only
// (R17) Latch applies to single or double per select
// (R18) Latched interrupt held until source read
// (R19) Latch ignored when interrupt not routed
// (R20) Slope is sample difference divided by two
// (R21) Second tap must start inside duration window
// (R22) Windows count accelerometer output samples
`ifndef TAPDET_DEFINES_SVH
`define TAPDET_DEFINES_SVH

`define TAPDET_SRC_ADDR 7'h1C
`define TAPDET_SRC_ANY 6
`define TAPDET_SRC_SINGLE 5
`define TAPDET_SRC_DOUBLE 4
`define TAPDET_SRC_SIGN 3
`define TAPDET_SRC_RESET 8'h00
`define TAPDET_THS_SHIFT 10
`define TAPDET_SHOCK_BASE 9'h004
`define TAPDET_SHOCK_STEP 9'h008
`define TAPDET_QUIET_BASE 9'h002
`define TAPDET_QUIET_STEP 9'h004
`define TAPDET_DUR_BASE 9'h010
`define TAPDET_DUR_STEP 9'h020

`endif

// ==== hw/tapdet_pkg.sv ====
// Types shared by the tap event detector
package tapdet_pkg;

    // Axis 2 is X, 1 is Y, 0 is Z, matching the source register bits
    typedef struct packed {
        logic [2:0][15:0] axis;
    } tapdet_sample_type;

    typedef struct packed {
        logic [2:0] tap_axis_en;
        logic [4:0] tap_threshold_field;
        logic [1:0] shock_field;
        logic [1:0] quiet_field;
        logic [3:0] duration_window_field;
        logic latch_interrupt_enable;
        logic single_double_sel;
        logic pin1_single_route;
        logic pin1_double_route;
        logic pin2_single_route;
        logic pin2_double_route;
        logic inactive_state;
    } tapdet_cfg_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SHOCK1,
        ST_QUIET,
        ST_DUR,
        ST_SHOCK2,
        ST_QUIET2,
        ST_SETTLE
    } tapdet_state_type;

endpackage
